/* sep_core.v */
// Serial command port of a 128 by 16 nonvolatile memory, with its storage.
// Assumes the host keeps select low between commands and waits out busy.
`timescale 1ns/1ps
`default_nettype none
`include "sep_regs.vh"
module sep_core #(
  parameter PROG_CYCLES = `SEP_PROG_CYCLES,
  parameter CNT_W = 18,
  parameter AW = 7,
  parameter DW = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Serial pins
  input wire device_select,
  input wire serial_clock_in,
  input wire serial_in,
  output reg serial_out,
  output reg serial_out_oe_n,
  // Status
  output wire busy,
  output wire write_unlocked
);
  localparam ST_IDLE = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_READ = 3'h3;
  localparam ST_DONE = 3'h4;
  localparam PEND_NONE = 3'h0;
  localparam PEND_WRITE = 3'h1;
  localparam PEND_FILL = 3'h2;
  localparam PEND_ERASE = 3'h3;
  localparam PEND_WIPE = 3'h4;
  // The count is worked out at full width first and cut to the timer width on purpose.
  localparam [31:0] PROG_LAST_W = PROG_CYCLES - 1;
  localparam [CNT_W-1:0] PROG_LAST = PROG_LAST_W[CNT_W-1:0];

  reg [DW-1:0] mem [0:(1<<AW)-1];
  wire [2:0] pin_q;
  wire [2:0] pin_qd;
  wire sel;
  wire sel_fall;
  wire sck_rise;
  wire din;
  reg [2:0] state_ff;
  reg [3:0] cnt_ff;
  reg [8:0] cmd_ff;
  reg [AW-1:0] addr_ff;
  reg [DW-1:0] shift_ff;
  reg [2:0] pend_ff;
  reg [2:0] prog_ff;
  reg unlock_ff;
  reg busy_ff;
  reg status_ff;
  reg dout_ff;
  reg [CNT_W-1:0] prog_cnt_ff;
  wire [9:0] cmd_full;
  wire [DW-1:0] data_full;
  integer i;

  sep_sync #(.WIDTH(3)) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d({device_select, serial_clock_in, serial_in}),
    .q(pin_q),
    .q_d(pin_qd)
  );

  // Data is taken from the same synchroniser stage as the clock edge, so both stay aligned.
  assign sel = pin_q[2];
  assign sel_fall = pin_qd[2] & ~pin_q[2];
  assign sck_rise = sel & pin_q[1] & ~pin_qd[1];
  assign din = pin_q[0];
  assign cmd_full = {cmd_ff, din};
  assign data_full = {shift_ff[DW-2:0], din};
  assign busy = busy_ff;
  assign write_unlocked = unlock_ff;

  // Frame sequencing; a fall of select always returns to idle.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      cmd_ff <= 9'h000;
      addr_ff <= {AW{1'b0}};
      shift_ff <= {DW{1'b0}};
      pend_ff <= PEND_NONE;
      unlock_ff <= 1'b0;
      status_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else if (sel_fall || !sel) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      dout_ff <= 1'b0;
      pend_ff <= PEND_NONE;
      if (busy_ff || prog_ff != PEND_NONE) begin
        status_ff <= 1'b1;
      end
    end else if (sck_rise) begin
      case (state_ff)
        ST_IDLE: begin
          // Commands are refused while programming runs.
          if (din && !busy_ff) begin
            state_ff <= ST_CMD;
            status_ff <= 1'b0;
            cnt_ff <= 4'h0;
          end
        end
        ST_CMD: begin
          cmd_ff <= cmd_full[8:0];
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == `SEP_CMD_BITS) begin
            cnt_ff <= 4'h0;
            addr_ff <= cmd_full[AW-1:0];
            state_ff <= ST_DONE;
            case (cmd_full[9:8])
              `SEP_OP_READ: begin
                dout_ff <= 1'b0;
                shift_ff <= mem[cmd_full[AW-1:0]];
                state_ff <= ST_READ;
              end
              `SEP_OP_WRITE: begin
                state_ff <= ST_DATA;
                pend_ff <= PEND_WRITE;
              end
              `SEP_OP_ERASE: begin
                pend_ff <= unlock_ff ? PEND_ERASE : PEND_NONE;
              end
              default: begin
                case (cmd_full[7:6])
                  `SEP_EXT_UNLOCK: unlock_ff <= 1'b1;
                  `SEP_EXT_LOCK: unlock_ff <= 1'b0;
                  `SEP_EXT_FILL: begin
                    state_ff <= ST_DATA;
                    pend_ff <= PEND_FILL;
                  end
                  default: pend_ff <= unlock_ff ? PEND_WIPE : PEND_NONE;
                endcase
              end
            endcase
          end
        end
        ST_DATA: begin
          shift_ff <= data_full;
          cnt_ff <= cnt_ff + 4'h1;
          // The command only arms once all sixteen bits are in; an early deselect drops it.
          if (cnt_ff == `SEP_DATA_BITS) begin
            state_ff <= ST_DONE;
            if (!unlock_ff) begin
              pend_ff <= PEND_NONE;
            end
          end
        end
        ST_READ: begin
          dout_ff <= shift_ff[DW-1];
          shift_ff <= {shift_ff[DW-2:0], 1'b0};
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == `SEP_DATA_BITS) begin
            cnt_ff <= 4'h0;
            addr_ff <= addr_ff + {{(AW-1){1'b0}}, 1'b1};
            shift_ff <= mem[addr_ff + {{(AW-1){1'b0}}, 1'b1}];
          end
        end
        default: begin
          state_ff <= ST_DONE;
        end
      endcase
    end
  end

  // Programming timer; an armed command starts only on the fall of select.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      prog_ff <= PEND_NONE;
      prog_cnt_ff <= {CNT_W{1'b0}};
    end else if (sel_fall && state_ff == ST_DONE && pend_ff != PEND_NONE && !busy_ff) begin
      busy_ff <= 1'b1;
      prog_ff <= pend_ff;
      prog_cnt_ff <= {CNT_W{1'b0}};
    end else if (busy_ff) begin
      if (prog_cnt_ff == PROG_LAST) begin
        busy_ff <= 1'b0;
        prog_ff <= PEND_NONE;
      end else begin
        prog_cnt_ff <= prog_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Cells take their new value at the end of the cycle; erase is implied by overwrite.
  always @(posedge ref_clk) begin
    if (busy_ff && prog_cnt_ff == PROG_LAST) begin
      case (prog_ff)
        PEND_WRITE: mem[addr_ff] <= shift_ff;
        PEND_ERASE: mem[addr_ff] <= `SEP_ERASED_WORD;
        PEND_FILL: begin
          for (i = 0; i < (1<<AW); i = i + 1) begin
            mem[i] <= shift_ff;
          end
        end
        PEND_WIPE: begin
          for (i = 0; i < (1<<AW); i = i + 1) begin
            mem[i] <= `SEP_ERASED_WORD;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Output stage; released whenever select is low.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out_oe_n <= ~sel;
      if (status_ff && state_ff == ST_IDLE) begin
        serial_out <= ~busy_ff;
      end else begin
        serial_out <= dout_ff;
      end
    end
  end
endmodule
`default_nettype wire

/* sep_core_props.sv */
// Checker for the serial command port, bound to every sep_core.
// Assumes the serial clock stays high for four core cycles or more.
`timescale 1ns/1ps
`default_nettype none
module sep_core_props #(parameter PROG_CYCLES = 50) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pins and status
  input wire logic device_select,
  input wire logic serial_clock_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic busy,
  input wire logic write_unlocked
);
  localparam int PMIN = PROG_CYCLES - 2;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_oe_idle: assert property (!device_select [*5] |-> serial_out_oe_n)
    else $error("driven while deselected");
  a_oe_drive: assert property (device_select [*5] |-> !serial_out_oe_n)
    else $error("not driven while selected");
  a_busy_len: assert property ($rose(busy) |-> ##PMIN busy ##[1:4] !busy)
    else $error("busy length");
  a_busy_start: assert property ($rose(busy) |-> !device_select && write_unlocked)
    else $error("busy without fall or unlock");
  a_busy_hold: assert property (busy |-> $stable(write_unlocked))
    else $error("command taken while busy");
  a_unlock_sel: assert property ($changed(write_unlocked) |-> device_select)
    else $error("lock state moved idle");
  a_status_busy: assert property (busy && $past(busy, 2) && !serial_out_oe_n |-> !serial_out)
    else $error("busy not shown low");
  // Status edges from programming are excluded; only read bits follow the clock.
  a_out_edge: assert property ($changed(serial_out) && !serial_out_oe_n && !$past(serial_out_oe_n)
    && !$past(busy) && !$past(busy, 2) |-> $past(serial_clock_in, 3))
    else $error("output moved off a clock rise");
  c_prog: cover property ($rose(busy));
  c_lock: cover property ($fell(write_unlocked));
  c_ready: cover property (!serial_out_oe_n && serial_out && !busy);
endmodule
bind sep_core sep_core_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.ref_clk(ref_clk),
  .rst_n(rst_n), .device_select(device_select), .serial_clock_in(serial_clock_in),
  .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .busy(busy),
  .write_unlocked(write_unlocked));
`default_nettype wire

/* sep_core_tb.sv */
// Bench for the serial command port with a host model.
// Assumes programming is shortened to fifty core cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t mismatch", $time); end end
module sep_core_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic sel, sck, sdi, sdo, oe_n, busy, unl;
  wire logic pin = oe_n ? 1'bz : sdo;
  logic [63:0] r;
  logic [15:0] d, w0, w1;
  logic [6:0] a;
  logic b0, b1;
  int fails = 0;
  int n_tests = 0;
  sep_core #(.PROG_CYCLES(50)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .device_select(sel),
    .serial_clock_in(sck), .serial_in(sdi), .serial_out(sdo), .serial_out_oe_n(oe_n),
    .busy(busy), .write_unlocked(unl));
  sep_host h (.device_select(sel), .serial_clock_in(sck), .serial_in(sdi), .serial_out(pin));
  function automatic [10:0] hdr(input [1:0] op, input [7:0] ad);
    hdr = {1'b1, op, ad};
  endfunction
  task automatic prog(input [10:0] c);
    h.xfer({c, d}, 27, r);
    h.poll(b0, b1);
    `CHK(b0, 1'b0)
    `CHK(b1, 1'b1)
  endtask
  task automatic rd(input [6:0] ad, input [15:0] e);
    h.xfer({hdr(2'h2, {1'b0, ad}), 16'h0}, 27, r);
    `CHK(r[16:0], {1'b0, e})
    `CHK(oe_n, 1'b1)
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #1000000;
    fails++;
    end_sim();
  end
  initial begin
    d = $urandom(32'h2c39);
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    `CHK(unl, 1'b0)
    h.xfer({6'h0, hdr(2'h0, {2'h3, 6'($urandom)})}, 17, r);
    `CHK(unl, 1'b1)
    $display("unlock done");
    a = 7'h7f;
    for (int k = 0; k < 2; k++) begin
      d = $urandom;
      w0 = d;
      prog(hdr(2'h1, {1'b0, a}));
      d = $urandom;
      w1 = d;
      prog(hdr(2'h1, {1'b0, a + 7'h1}));
      h.xfer({hdr(2'h2, {1'b0, a}), 32'h0}, 43, r);
      `CHK(r[32:0], {1'b0, w0, w1})
      a = $urandom;
    end
    $display("write and read done");
    prog(hdr(2'h3, {1'b0, a}));
    rd(a, 16'hffff);
    prog(hdr(2'h0, {2'h2, 6'($urandom)}));
    rd(7'h7f, 16'hffff);
    d = $urandom;
    prog(hdr(2'h0, {2'h1, 6'($urandom)}));
    rd(a ^ 7'h55, d);
    $display("erase and fill done");
    h.xfer(hdr(2'h0, {2'h0, 6'($urandom)}), 11, r);
    `CHK(unl, 1'b0)
    for (int k = 0; k < 4; k++) begin
      h.xfer({hdr(k[1:0], {k[1:0] == 2'h0 ? 2'h1 : 2'h2, 6'h0}), d ^ 16'h1}, 27, r);
      `CHK(busy, 1'b0)
    end
    rd(a, d);
    $display("lock done");
    end_sim();
  end
endmodule
`default_nettype wire

/* sep_host.sv */
// Host model driving the port's serial pins.
// Assumes each call starts just after a core clock edge.
`timescale 1ns/1ps
`default_nettype none
module sep_host (
  // Pins toward the port
  output logic device_select,
  output logic serial_clock_in,
  output logic serial_in,
  // Pin from the port
  input wire logic serial_out
);
  initial begin
    device_select = 1'b0;
    serial_clock_in = 1'b0;
    serial_in = 1'b0;
  end
  // The clock stands low between frames; data flips so stale bits never look valid.
  task automatic xfer(input logic [63:0] b, input int n, output logic [63:0] r);
    r = '0;
    device_select = 1'b1;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      r = {r[62:0], serial_out};
      serial_in = b[i];
      #160 serial_clock_in = 1'b1;
      #160 serial_clock_in = 1'b0;
    end
    r = {r[62:0], serial_out};
    device_select = 1'b0;
    serial_in = ~serial_in;
    #480;
  endtask
  task automatic poll(output logic b0, output logic b1);
    device_select = 1'b1;
    serial_in = 1'b0;
    #240 b0 = serial_out;
    for (int i = 0; i < 300 && serial_out !== 1'b1; i++) #40;
    b1 = serial_out;
    device_select = 1'b0;
    serial_in = 1'b1;
    #480;
  endtask
endmodule
`default_nettype wire

/* sep_regs.vh */
// Constants for the four-wire serial memory command port.
// Assumes a 25 MHz core clock and a host that keeps the serial timing limits.
`ifndef SEP_REGS_VH
`define SEP_REGS_VH

`define SEP_OP_EXT 2'h0
`define SEP_OP_WRITE 2'h1
`define SEP_OP_READ 2'h2
`define SEP_OP_ERASE 2'h3
`define SEP_EXT_LOCK 2'h0
`define SEP_EXT_FILL 2'h1
`define SEP_EXT_WIPE 2'h2
`define SEP_EXT_UNLOCK 2'h3
`define SEP_CMD_BITS 4'h9
`define SEP_DATA_BITS 4'hf
`define SEP_ERASED_WORD 16'hffff
`define SEP_CLK_MHZ 25
`define SEP_PROG_TIME_US 10000
`define SEP_PROG_CYCLES (`SEP_PROG_TIME_US * `SEP_CLK_MHZ)

`endif

/* sep_sync.v */
// Two-stage synchroniser with a third stage for edge detection.
// Assumes the inputs are asynchronous to clk; only q and q_d are read outside.
`timescale 1ns/1ps
`default_nettype none
module sep_sync #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Pins and synchronised copies
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q,
  output reg [WIDTH-1:0] q_d
);
  reg [WIDTH-1:0] meta_ff;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
      q_d <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= d;
      q <= meta_ff;
      q_d <= q;
    end
  end
endmodule
`default_nettype wire
